// *** src/spbx_xfer.sv ***
// Summary of operation
// - Device-7 select address works like device 0, using device 7 settings and select 7.
// - Master mode when master_slave_select is 0: drive clock, send and receive data.
// - Master: first byte write shows the MSB at once and clears done.
// - After 8 or 16 bits done is set and data output is released.
// - Plain data register transfers use device 7 word length and polarity.
// - Slave mode when master_slave_select is 1: shift on the external clock pin.
// - Slave: while done, output released and external clock edges ignored.
// - Slave: first byte write starts shifting until 8 or 16 pulses, then done.
// - Slave: select addresses give no automatic chip select; select port stays general.
// - Shared-line peripherals use one data line, direction agreed by byte protocol.
// - After reset every chip select pin is an input until direction set.
// - Reset clears master_slave_select and data_out_input_select: master, output data pin.
// - Done raises the interrupt when enabled, only in non-multiplexed bus format.
// - With data_out_input_select set, the data output pin feeds the receive register.
// - Hardware select low only during transfer; software-held low overrides hardware.
`include "spbx_map.svh"

module spbx_xfer (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic [4:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       BUS_NONMUX,
  output logic            SCLK_OUT,
  input  wire logic       DEVICE_CLOCK_IN,
  input  wire logic       SDI,
  output logic            SDO_OUT,
  output logic            SDO_OE,
  input  wire logic       SDO_IN,
  output logic      [7:0] CS_OUT,
  output logic      [7:0] CS_OE,
  input  wire logic [7:0] CS_IN,
  output logic            INT_N
);
  import spbx_pkg::*;

  spbx_regs_type st;
  spbx_regs_type next_st;

  logic        pol;
  logic        wide;
  logic [4:0]  nbits;
  logic [11:0] lvl;
  logic        rx_pin;
  logic        tick;
  logic [6:0]  half_m1;
  logic        lead;
  logic        trail;
  logic        rise;
  logic        fall;
  logic        sel_addr;
  logic        start;
  logic [7:0]  hw_mask;

  always_comb begin
    next_st = st;
    // pins pass three stages; a level counts once stages two and three agree
    next_st.s1 = {BUS_NONMUX, DEVICE_CLOCK_IN, SDO_IN, SDI, CS_IN};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // agreed level is used at once: an extra stage would let a 200 ns clock level outrun the shift
    lvl = (st.s2 & ~(st.s2 ^ st.s3)) | (st.filt & (st.s2 ^ st.s3));
    next_st.filt = lvl;
    rise = lvl[`SPBX_SYNC_CLK_IN] & ~st.filt[`SPBX_SYNC_CLK_IN];
    fall = ~lvl[`SPBX_SYNC_CLK_IN] & st.filt[`SPBX_SYNC_CLK_IN];

    pol = st.skp[st.dev];
    wide = st.mwm[st.dev];
    nbits = wide ? `SPBX_BITS_LONG : `SPBX_BITS_SHORT;
    rx_pin = st.soi ? lvl[`SPBX_SYNC_SDO_IN] : lvl[`SPBX_SYNC_SDI];

    half_m1 = 7'((8'h01 << st.div) - 8'h01);
    tick = (st.div_cnt == half_m1);
    next_st.div_cnt = (tick || st.fsm == SPBX_IDLE) ? 7'h00 : 7'(st.div_cnt + 7'h01);

    lead = 1'b0;
    trail = 1'b0;
    case (st.fsm)
      SPBX_IDLE: begin
        next_st.sk = pol;
      end
      SPBX_SETUP: begin
        // idle level of the newly addressed device
        next_st.sk = pol;
        // select settles a clock period, less one CLK cycle, before the first edge: half here, half in shift
        if (tick) begin
          next_st.fsm = SPBX_SHIFT;
        end
      end
      SPBX_SHIFT: begin
        if (st.ms) begin
          lead = pol ? fall : rise;
          trail = pol ? rise : fall;
        end else if (tick) begin
          next_st.sk = ~st.sk;
          lead = (st.sk == pol);
          trail = (st.sk != pol);
        end
      end
      SPBX_HOLD: begin
        if (tick) begin
          next_st.fsm = SPBX_IDLE;
          next_st.hw_cs = 1'b0;
          next_st.done = 1'b1;
        end
      end
      default: begin
        next_st.fsm = SPBX_IDLE;
      end
    endcase

    if (lead) begin
      next_st.rxbit = rx_pin;
    end
    if (trail) begin
      if (wide) begin
        next_st.sh = {st.sh[14:0], st.rxbit};
      end else begin
        next_st.sh[15:8] = {st.sh[14:8], st.rxbit};
      end
      next_st.cnt = 5'(st.cnt + 5'h01);
      if (5'(st.cnt + 5'h01) == nbits) begin
        // slave finishes on the last pulse
        // master reports done after the hold, so a start is never refused while done reads one
        next_st.done = st.ms;
        next_st.oe = 1'b0;
        next_st.fsm = st.ms ? SPBX_IDLE : SPBX_HOLD;
      end
    end

    // data writes are refused while a word is in flight
    sel_addr = (ADDR[4:3] == `SPBX_ADDR_SELECT_BASE);
    start = WR && st.fsm == SPBX_IDLE && (sel_addr || ADDR == `SPBX_ADDR_FIRST_BYTE);
    if (start) begin
      // msb shown at once, done cleared
      next_st.sh[15:8] = WDATA;
      next_st.done = 1'b0;
      // shared line stays undriven when turned to input
      next_st.oe = ~st.soi;
      next_st.cnt = 5'h00;
      next_st.rxbit = 1'b0;
      // no automatic select in slave mode
      next_st.hw_cs = sel_addr && !st.ms;
      // device and select taken from a select address in master mode, else device 7
      next_st.dev = (sel_addr && !st.ms) ? ADDR[2:0] : `SPBX_DEV_DEFAULT;
      next_st.fsm = st.ms ? SPBX_SHIFT : SPBX_SETUP;
    end else if (WR && ADDR == `SPBX_ADDR_SECOND_BYTE && st.fsm == SPBX_IDLE) begin
      next_st.sh[7:0] = WDATA;
    end else if (WR && ADDR == `SPBX_ADDR_CHIP_SELECT) begin
      next_st.cs = WDATA;
    end else if (WR && ADDR == `SPBX_ADDR_PIN_DIRECTION) begin
      next_st.pd = WDATA;
    end else if (WR && ADDR == `SPBX_ADDR_POLARITY) begin
      next_st.skp = WDATA;
    end else if (WR && ADDR == `SPBX_ADDR_WORD_MODE) begin
      next_st.mwm = WDATA;
    end else if (WR && ADDR == `SPBX_ADDR_CLOCK_RATE) begin
      next_st.div = WDATA[2:0];
      next_st.inten = WDATA[`SPBX_BIT_IRQ_ENABLE];
    end else if (WR && ADDR == `SPBX_ADDR_CLOCK_CTRL) begin
      next_st.ms = WDATA[`SPBX_BIT_MASTER_SLAVE];
      next_st.soi = WDATA[`SPBX_BIT_DATA_OUT_IN];
    end

    // hardware can only pull low; a software low wins
    hw_mask = st.hw_cs ? 8'(8'h01 << st.dev) : 8'h00;
    next_st.cs_out = st.cs & ~hw_mask;
    // interrupt gated by enable and bus format
    next_st.int_n = ~(st.done & st.inten & lvl[`SPBX_SYNC_NONMUX]);

    if (RD) begin
      if (ADDR == `SPBX_ADDR_FIRST_BYTE || sel_addr) begin
        next_st.rdata = st.sh[15:8];
      end else if (ADDR == `SPBX_ADDR_SECOND_BYTE) begin
        next_st.rdata = st.sh[7:0];
      end else if (ADDR == `SPBX_ADDR_CHIP_SELECT) begin
        // output pins read as one, inputs show the pin
        next_st.rdata = (st.filt[7:0] & ~st.pd) | st.pd;
      end else if (ADDR == `SPBX_ADDR_PIN_DIRECTION) begin
        next_st.rdata = st.pd;
      end else if (ADDR == `SPBX_ADDR_STATUS) begin
        next_st.rdata = {st.done, 7'h00};
      end else if (ADDR == `SPBX_ADDR_POLARITY) begin
        next_st.rdata = st.skp;
      end else if (ADDR == `SPBX_ADDR_WORD_MODE) begin
        next_st.rdata = st.mwm;
      end else if (ADDR == `SPBX_ADDR_CLOCK_RATE) begin
        next_st.rdata = {st.inten, 4'h0, st.div};
      end else if (ADDR == `SPBX_ADDR_CLOCK_CTRL) begin
        next_st.rdata = {6'h00, st.soi, st.ms};
      end else begin
        next_st.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
      st.done <= `SPBX_RST_DONE;
      st.pd <= `SPBX_RST_PIN_DIRECTION;
      st.cs <= `SPBX_RST_CHIP_SELECT;
      st.cs_out <= `SPBX_RST_CHIP_SELECT;
      // master mode, data pin as output
      st.ms <= 1'b0;
      st.soi <= 1'b0;
      st.int_n <= 1'b1;
      st.dev <= `SPBX_DEV_DEFAULT;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA = st.rdata;
  assign SCLK_OUT = st.sk;
  assign SDO_OUT = st.sh[15];
  assign SDO_OE = st.oe;
  assign CS_OUT = st.cs_out;
  assign CS_OE = st.pd;
  assign INT_N = st.int_n;

endmodule : spbx_xfer

// *** src/spbx_map.svh ***
`ifndef SPBX_MAP_SVH
`define SPBX_MAP_SVH

// register addresses on the parallel host port
`define SPBX_ADDR_FIRST_BYTE    5'h00
`define SPBX_ADDR_SECOND_BYTE   5'h01
`define SPBX_ADDR_CHIP_SELECT   5'h02
`define SPBX_ADDR_PIN_DIRECTION 5'h03
`define SPBX_ADDR_STATUS        5'h04
`define SPBX_ADDR_POLARITY      5'h05
`define SPBX_ADDR_WORD_MODE     5'h06
`define SPBX_ADDR_CLOCK_RATE    5'h07
`define SPBX_ADDR_CLOCK_CTRL    5'h08
// first_byte_with_select for device n sits at 0x10 plus n; this base is matched against address bits 4:3
`define SPBX_ADDR_SELECT_BASE   2'h2

// field positions
`define SPBX_BIT_DONE           7
`define SPBX_BIT_IRQ_ENABLE     7
`define SPBX_BIT_MASTER_SLAVE   0
`define SPBX_BIT_DATA_OUT_IN    1

// reset values
`define SPBX_RST_CHIP_SELECT    8'hFF
`define SPBX_RST_PIN_DIRECTION  8'h00
`define SPBX_RST_DONE           1'b1

// word lengths in clock cycles of the serial clock
`define SPBX_BITS_SHORT         5'h08
`define SPBX_BITS_LONG          5'h10
`define SPBX_DEV_DEFAULT        3'h7

// positions inside the synchronised pin vector
`define SPBX_SYNC_SDI           8
`define SPBX_SYNC_SDO_IN        9
`define SPBX_SYNC_CLK_IN        10
`define SPBX_SYNC_NONMUX        11

`endif

// *** src/spbx_pkg.sv ***
package spbx_pkg;

  typedef enum logic [1:0] {
    SPBX_IDLE  = 2'b00,
    SPBX_SETUP = 2'b01,
    SPBX_SHIFT = 2'b10,
    SPBX_HOLD  = 2'b11
  } spbx_state_type;

  typedef struct packed {
    spbx_state_type fsm;
    logic [15:0]    sh;
    logic           rxbit;
    logic [4:0]     cnt;
    logic [6:0]     div_cnt;
    logic           sk;
    logic           oe;
    logic           done;
    logic [2:0]     dev;
    logic           hw_cs;
    logic [7:0]     cs;
    logic [7:0]     pd;
    logic [7:0]     skp;
    logic [7:0]     mwm;
    logic [2:0]     div;
    logic           inten;
    logic           ms;
    logic           soi;
    logic [11:0]    s1;
    logic [11:0]    s2;
    logic [11:0]    s3;
    logic [11:0]    filt;
    logic [7:0]     cs_out;
    logic           int_n;
    logic [7:0]     rdata;
  } spbx_regs_type;

endpackage : spbx_pkg

// *** tb/spbx_chk.sv ***
module spbx_chk (
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       BUS_NONMUX,
  input wire logic       SCLK_OUT,
  input wire logic       SDO_OUT,
  input wire logic       SDO_OE,
  input wire logic [7:0] CS_OUT,
  input wire logic [7:0] CS_OE,
  input wire logic       INT_N
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic [5:0] n;
  logic       sk_d;
  logic       slv;
  logic       cs7;
  wire        st = WR && (ADDR == 5'h00 || ADDR[4:3] == 2'b10) && !SDO_OE;
  // serial clock toggles since the last start; idle level moves only in idle and in setup, before the first shift edge
  // slave mode and the software select bit 7 are tracked from the host writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      n    <= 6'h00;
      sk_d <= 1'b0;
      slv  <= 1'b0;
      cs7  <= 1'b1;
    end else begin
      sk_d <= SCLK_OUT;
      n    <= st ? 6'h00 : n + {5'h00, SCLK_OUT ^ sk_d};
      slv  <= (WR && ADDR == 5'h08) ? WDATA[0] : slv;
      cs7  <= (WR && ADDR == 5'h02) ? WDATA[7] : cs7;
    end
  end
  a_start_msb: assert property (st |=> SDO_OUT == $past(WDATA[7]))
    else $error("msb not presented after start");
  // the last toggle is counted one edge after the output is released
  a_bit_count: assert property ($fell(SDO_OE) && n != 6'h00 |-> n == 6'h0F || n == 6'h1F)
    else $error("wrong serial clock count");
  a_busy_status: assert property (RD && ADDR == 5'h04 ##0 SDO_OE ##1 SDO_OE |-> RDATA == 8'h00)
    else $error("status not busy while driving");
  a_pin_dir: assert property (WR && ADDR == 5'h03 |-> ##2 CS_OE == $past(WDATA, 2))
    else $error("pin direction not applied");
  a_cs_port: assert property (WR && ADDR == 5'h02 && !SDO_OE |-> ##2 CS_OUT == $past(WDATA, 2))
    else $error("select port not applied");
  a_int_gate: assert property (!BUS_NONMUX [*5] |-> INT_N)
    else $error("interrupt in multiplexed format");
  a_hw_select: assert property (WR && ADDR == 5'h17 && !SDO_OE && !slv |-> ##2 !CS_OUT[7])
    else $error("select 7 not driven low");
  a_hw_release: assert property ($fell(SDO_OE) && !CS_OUT[7] && cs7 |-> ##[1:300] CS_OUT[7])
    else $error("select 7 not released");
  cover property (st);
  cover property ($fell(SDO_OE));
  cover property (!INT_N);
endmodule : spbx_chk

bind spbx_xfer spbx_chk u_chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .BUS_NONMUX(BUS_NONMUX), .SCLK_OUT(SCLK_OUT), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE),
  .CS_OUT(CS_OUT), .CS_OE(CS_OE), .INT_N(INT_N));

// *** tb/spbx_peer.sv ***
module spbx_peer (
  input wire logic        sk,
  input wire logic        sel_n,
  input wire logic        pol,
  input wire logic        so,
  input wire logic        load,
  input wire logic [15:0] tx,
  output logic            si,
  output logic [15:0]     rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sr = 16'h0000;
  initial rx = 16'h0000;
  always @(posedge (sk ^ pol)) if (!sel_n) rx <= {rx[14:0], so};
  always @(negedge (sk ^ pol) or posedge load) begin
    if (load) sr <= tx;
    else if (!sel_n) sr <= {sr[14:0], 1'b0};
  end
  // deselected line shows the inverse, never a stale bit
  assign si = sr[15] ^ sel_n;
endmodule : spbx_peer

// *** tb/spbx_xfer_tb_top.sv ***
module spbx_xfer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, resetn = 0, wr = 0, rd = 0, nonmux = 0, dci = 0;
  logic        shared = 0, ms = 0, pol = 0, load = 0, si, sdo, sdo_oe, sclk, int_n;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00, rdata, cs_out, cs_oe, d;
  logic [15:0] tx = 16'h0000, rx;
  int          bad_count = 0, total_checks = 0, cyc = 0;
  wire         sk = ms ? dci : sclk;
  wire         sel_n = ms ? 1'b0 : &cs_out;
  wire         sdo_in = sdo_oe ? sdo : (shared ? si : ~sdo);
  wire         sdi = shared ? ~si : si;
  spbx_xfer DUT (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .BUS_NONMUX(nonmux), .SCLK_OUT(sclk), .DEVICE_CLOCK_IN(dci), .SDI(sdi), .SDO_OUT(sdo), .SDO_OE(sdo_oe),
    .SDO_IN(sdo_in), .CS_OUT(cs_out), .CS_OE(cs_oe), .CS_IN(cs_out), .INT_N(int_n));
  spbx_peer u_peer (.sk(sk), .sel_n(sel_n), .pol(pol), .so(sdo_in), .load(load), .tx(tx), .si(si), .rx(rx));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask : bus_wr
  task automatic bus_rd(input logic [4:0] a);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdata;
  endtask : bus_rd
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wait_done;
    d = 8'h00;
    for (int i = 0; i < 300 && d[7] !== 1'b1; i++) bus_rd(5'h04);
    chk("done", 16'h0080, {8'h00, d});
  endtask : wait_done
  task automatic start(input logic [15:0] w);
    tx = w;
    load = 1;
    #1 load = 0;
  endtask : start
  task automatic pulses(input int n);
    repeat (n) begin
      #200 dci = 1;
      #200 dci = 0;
    end
  endtask : pulses
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // hang guard, a few hundred cycles are expected
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    resetn = 1;
    repeat (5) @(negedge clk);
    chk("cs_oe", 16'h0000, {8'h00, cs_oe});
    bus_rd(5'h08);
    chk("ctrl", 16'h0000, {8'h00, d});
    $display("test reset ok");
    nonmux = 1;
    bus_wr(5'h03, 8'hFF);
    bus_wr(5'h05, 8'h00);
    bus_wr(5'h06, 8'h00);
    bus_wr(5'h07, 8'h82);
    start(16'h3C00);
    bus_wr(5'h17, 8'hA5);
    wait_done;
    chk("rx7", 16'h00A5, {8'h00, rx[7:0]});
    bus_rd(5'h00);
    chk("fmb7", 16'h003C, {8'h00, d});
    chk("int", 16'h0000, {15'h0000, int_n});
    repeat (8) @(negedge clk);
    chk("cs7", 16'h00FF, {8'h00, cs_out});
    $display("test select ok");
    bus_wr(5'h05, 8'h82);
    pol = 1;
    bus_wr(5'h06, 8'h80);
    bus_wr(5'h02, 8'hFD);
    start(16'hBEEF);
    bus_wr(5'h01, 8'h34);
    bus_wr(5'h00, 8'h12);
    wait_done;
    bus_wr(5'h02, 8'hFF);
    chk("rx16", 16'h1234, rx);
    bus_rd(5'h00);
    chk("fmb", 16'h00BE, {8'h00, d});
    bus_rd(5'h01);
    chk("smb", 16'h00EF, {8'h00, d});
    $display("test word ok");
    bus_wr(5'h06, 8'h00);
    bus_wr(5'h11, 8'h81);
    wait_done;
    bus_wr(5'h08, 8'h02);
    shared = 1;
    start(16'hC300);
    bus_wr(5'h11, 8'h00);
    wait_done;
    bus_rd(5'h11);
    chk("shared", 16'h00C3, {8'h00, d});
    bus_wr(5'h08, 8'h00);
    shared = 0;
    $display("test shared ok");
    bus_wr(5'h05, 8'h00);
    pol = 0;
    bus_wr(5'h08, 8'h01);
    ms = 1;
    bus_wr(5'h02, 8'hF7);
    start(16'h9600);
    bus_wr(5'h00, 8'h5A);
    pulses(8);
    wait_done;
    chk("rx_slv", 16'h005A, {8'h00, rx[7:0]});
    pulses(4);
    repeat (6) @(negedge clk);
    bus_rd(5'h00);
    chk("fmb_slv", 16'h0096, {8'h00, d});
    chk("oe_slv", 16'h0000, {15'h0000, sdo_oe});
    nonmux = 0;
    repeat (6) @(negedge clk);
    chk("int_off", 16'h0001, {15'h0000, int_n});
    $display("test slave ok");
    final_report;
  end
endmodule : spbx_xfer_tb_top
